// >>> design/rhdp_pkg.sv
// constants and types for the repeater host/display pin port
// Functional notes
// - the device strobes each display word and port number into the off-chip display latches.
// - while a host read or write strobe is asserted the latch strobe stays inactive high.
// - during display update cycles all eight data pins are outputs carrying status and port number.
// - the data pins stay driven as display outputs at all times except while a host strobe is asserted or load/reset is low.
// - during a host access the lower four pins carry the data nibble, driven by the host on write, by the device on read.
// - the direction of the data pins follows the read, write and load/reset inputs.
// - a host write pulse stores the data nibble into the internal register chosen by the upper four pins.
// - a host read returns on the data nibble the internal register chosen by the upper four pins.
// - after each transmitted packet the freeze strobe goes high and status stays frozen until the next received packet, at most 30 ms.
// - one output controls whether the external bus transceiver is driven or high impedance.
// - the transceiver gate is high during display update cycles and low during host access or load cycles.
// - while load/reset is low all state machines are reset and held inactive.
// - on the rising edge of load/reset the eight data pins are captured into the configuration register.
// - the display test sequence begins on the rising edge of load/reset.
// - the display scan phases step at a single 20 MHz rate; host steps and the freeze count run at the 100 MHz clock.
package rhdp_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned STATE_HZ = 20_000_000;
  localparam int unsigned DIV_CNT = CLK_HZ / STATE_HZ;
  localparam int unsigned DIV_W = 3;
  localparam int unsigned FREEZE_MS = 30;
  localparam int unsigned FREEZE_CYC_DEF = FREEZE_MS * (CLK_HZ / 1000);
  localparam int unsigned FREEZE_W = 22;
  localparam int unsigned PORT_CNT = 7;
  localparam int unsigned PORT_W = 3;
  localparam int unsigned STAT_W = 5;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned NIB_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned SYNC_W = 11;
  localparam int unsigned SY_WR = 8;
  localparam int unsigned SY_RD = 9;
  localparam int unsigned SY_LD = 10;
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 11'h300;
  localparam logic [PORT_W-1:0] PORT_LAST = 3'h6;
  localparam logic [PORT_W-1:0] PORT_FIRST = 3'h0;
  localparam logic [2:0] TEST_SCANS = 3'h4;
  localparam logic [STAT_W-1:0] STAT_ALL_ON = 5'h1f;
  localparam logic [DATA_W-1:0] OE_ALL_DRIVE = 8'h00;
  localparam logic [DATA_W-1:0] OE_ALL_FLOAT = 8'hff;
  localparam logic [DATA_W-1:0] OE_LOW_NIB = 8'hf0;
  localparam logic [DATA_W-1:0] CONFIG_RESET = 8'h00;
  typedef enum logic [2:0] {ST_LOAD, ST_SETUP, ST_LATCH, ST_HOLD, ST_RELEASE, ST_HOST} scan_state_t;
endpackage : rhdp_pkg

// >>> design/rhdp_nibble_mem.sv
// sixteen four-bit host registers with registered read data
`timescale 1ns/10ps
module rhdp_nibble_mem import rhdp_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [ADDR_W-1:0] waddr,
  input wire logic [NIB_W-1:0] wdata,
  input wire logic [ADDR_W-1:0] raddr,
  output logic [NIB_W-1:0] rdata
);
  logic [NIB_W-1:0] mem [2**ADDR_W];

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 2**ADDR_W; i++) begin
        mem[i] <= '0;
      end
    end else if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule : rhdp_nibble_mem

// >>> design/repeater_host_display_port.sv
// shared data pin port: display scan, host register access, load/reset and freeze
`timescale 1ns/10ps
module repeater_host_display_port import rhdp_pkg::*; #(
  parameter int unsigned FREEZE_CYCLES = FREEZE_CYC_DEF
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [DATA_W-1:0] D_IN,
  output logic [DATA_W-1:0] D_OUT,
  output logic [DATA_W-1:0] D_OE_N,
  input wire logic WR_N,
  input wire logic RD_N,
  input wire logic CONFIG_CAPTURE_RESET_N,
  input wire logic [PORT_CNT*STAT_W-1:0] PORT_STATUS,
  input wire logic TX_PACKET_END,
  input wire logic RX_PACKET_START,
  output logic DISPLAY_LATCH_PULSE_N,
  output logic DISPLAY_FREEZE_PULSE,
  output logic TRANSCEIVER_GATE,
  output logic [DATA_W-1:0] CONFIG
);
  logic [SYNC_W-1:0] sy1, sy2, sy3, filt;
  logic [DIV_W-1:0] div_cnt;
  logic tick;
  scan_state_t state, next_state;
  logic [PORT_W-1:0] port;
  logic [2:0] test_cnt;
  logic [FREEZE_W-1:0] freeze_cnt;
  logic [PORT_CNT*STAT_W-1:0] snap;
  logic [STAT_W-1:0] shown;
  logic wr_q, mem_we;
  logic [ADDR_W-1:0] w_addr;
  logic [NIB_W-1:0] w_data, rd_nib;
  logic host_act, run, load_rise, disp_now;
  logic [FREEZE_W-1:0] frozen_for;

  // pins pass three flops; a change counts once the last two agree
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      sy1 <= SYNC_IDLE;
      sy2 <= SYNC_IDLE;
      sy3 <= SYNC_IDLE;
    end else begin
      sy1 <= {CONFIG_CAPTURE_RESET_N, RD_N, WR_N, D_IN};
      sy2 <= sy1;
      sy3 <= sy2;
    end
  end

  // load/reset resets low so the first release counts as a rising edge
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      filt <= {1'b0, SYNC_IDLE[SYNC_W-2:0]};
    end else begin
      for (int i = 0; i < SYNC_W; i++) begin
        if (sy2[i] == sy3[i]) begin
          filt[i] <= sy3[i];
        end
      end
    end
  end

  assign run = filt[SY_LD];
  assign host_act = !filt[SY_WR] || !filt[SY_RD];
  assign load_rise = (state == ST_LOAD) && run;
  assign disp_now = (state == ST_SETUP) || (state == ST_LATCH) || (state == ST_HOLD);

  always_ff @(posedge CLK_SYS) begin
    if (RST || div_cnt == DIV_W'(DIV_CNT - 1)) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end
  assign tick = (div_cnt == DIV_W'(DIV_CNT - 1));

  always_comb begin
    next_state = state;
    if (!run) begin
      next_state = ST_LOAD;
    end else begin
      unique case (state)
        ST_LOAD: next_state = host_act ? ST_RELEASE : ST_SETUP;
        ST_SETUP: next_state = host_act ? ST_RELEASE : (tick ? ST_LATCH : ST_SETUP);
        ST_LATCH: next_state = host_act ? ST_RELEASE : (tick ? ST_HOLD : ST_LATCH);
        ST_HOLD: next_state = host_act ? ST_RELEASE : (tick ? ST_SETUP : ST_HOLD);
        ST_RELEASE: next_state = ST_HOST;
        ST_HOST: next_state = host_act ? ST_HOST : ST_SETUP;
        default: next_state = ST_LOAD;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state <= ST_LOAD;
    end else begin
      state <= next_state;
    end
  end

  // port walk; an abandoned cycle restarts on the same port
  always_ff @(posedge CLK_SYS) begin
    if (RST || !run) begin
      port <= PORT_FIRST;
    end else if (state == ST_HOLD && tick && !host_act) begin
      port <= (port == PORT_LAST) ? PORT_FIRST : port + 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      CONFIG <= CONFIG_RESET;
    end else if (load_rise) begin
      CONFIG <= filt[DATA_W-1:0];
    end
  end

  // display test, all lamps on for a few scans
  always_ff @(posedge CLK_SYS) begin
    if (RST || !run) begin
      test_cnt <= '0;
    end else if (load_rise) begin
      test_cnt <= TEST_SCANS;
    end else if (state == ST_HOLD && tick && !host_act && port == PORT_LAST && test_cnt != '0) begin
      test_cnt <= test_cnt - 1'b1;
    end
  end

  // freeze: a packet end wins over a packet start in the same cycle
  always_ff @(posedge CLK_SYS) begin
    if (RST || !run) begin
      DISPLAY_FREEZE_PULSE <= 1'b0;
      freeze_cnt <= '0;
    end else if (TX_PACKET_END) begin
      DISPLAY_FREEZE_PULSE <= 1'b1;
      freeze_cnt <= FREEZE_W'(FREEZE_CYCLES - 1);
    end else if (RX_PACKET_START || freeze_cnt == '0) begin
      DISPLAY_FREEZE_PULSE <= 1'b0;
    end else begin
      freeze_cnt <= freeze_cnt - 1'b1;
    end
  end

  // cycles the freeze output has stood since its last trigger, for the upper bound check
  always_ff @(posedge CLK_SYS) begin
    if (RST || !DISPLAY_FREEZE_PULSE || TX_PACKET_END) begin
      frozen_for <= '0;
    end else begin
      frozen_for <= frozen_for + 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      snap <= '0;
    end else if (TX_PACKET_END) begin
      snap <= PORT_STATUS;
    end
  end

  always_comb begin
    // the load edge already shows the test pattern, the test count lands one edge later
    if (test_cnt != '0 || load_rise) begin
      shown = STAT_ALL_ON;
    end else if (DISPLAY_FREEZE_PULSE) begin
      shown = snap[port*STAT_W +: STAT_W];
    end else begin
      shown = PORT_STATUS[port*STAT_W +: STAT_W];
    end
  end

  // write lands when the strobe ends, using the address seen during it
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      wr_q <= 1'b0;
      w_addr <= '0;
      w_data <= '0;
    end else begin
      wr_q <= (state == ST_HOST) && !filt[SY_WR];
      if ((state == ST_HOST) && !filt[SY_WR]) begin
        w_addr <= filt[DATA_W-1:NIB_W];
        w_data <= filt[NIB_W-1:0];
      end
    end
  end
  assign mem_we = wr_q && filt[SY_WR] && run;

  // registered read of the addressed nibble
  rhdp_nibble_mem u_mem (
    .clk(CLK_SYS),
    .rst(RST),
    .we(mem_we),
    .waddr(w_addr),
    .wdata(w_data),
    .raddr(filt[DATA_W-1:NIB_W]),
    .rdata(rd_nib)
  );

  // latch strobe only in the latch phase, never under a host strobe
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      DISPLAY_LATCH_PULSE_N <= 1'b1;
    end else begin
      DISPLAY_LATCH_PULSE_N <= !(next_state == ST_LATCH);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      TRANSCEIVER_GATE <= 1'b0;
    end else begin
      TRANSCEIVER_GATE <= (next_state == ST_SETUP) || (next_state == ST_LATCH) || (next_state == ST_HOLD);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      D_OE_N <= OE_ALL_FLOAT;
      D_OUT <= '0;
    end else if (next_state == ST_SETUP || next_state == ST_LATCH || next_state == ST_HOLD) begin
      D_OE_N <= OE_ALL_DRIVE;
      D_OUT <= {shown, port};
    end else if (next_state == ST_HOST && !filt[SY_RD]) begin
      D_OE_N <= OE_LOW_NIB;
      D_OUT <= {{(DATA_W-NIB_W){1'b0}}, rd_nib};
    end else begin
      D_OE_N <= OE_ALL_FLOAT;
      D_OUT <= '0;
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  latch_idle_host_a: assert property (host_act |=> DISPLAY_LATCH_PULSE_N)
    else $error("latch strobe active under host strobe");
  latch_in_display_a: assert property ($fell(DISPLAY_LATCH_PULSE_N) |-> TRANSCEIVER_GATE && D_OE_N == OE_ALL_DRIVE)
    else $error("latch strobe outside display cycle");
  display_drive_a: assert property (TRANSCEIVER_GATE |-> D_OE_N == OE_ALL_DRIVE)
    else $error("display cycle without all pins driven");
  pins_kept_a: assert property ((disp_now && !host_act && run) |=> D_OE_N == OE_ALL_DRIVE)
    else $error("pins released without host strobe");
  release_first_a: assert property ((disp_now && host_act && run) |=> state == ST_RELEASE && D_OE_N == OE_ALL_FLOAT)
    else $error("pins not released before host access");
  read_nibble_a: assert property ((state == ST_HOST && !filt[SY_RD] && run) |=> D_OE_N == OE_LOW_NIB)
    else $error("read does not drive low nibble only");
  write_float_a: assert property ((state == ST_HOST && !filt[SY_WR] && filt[SY_RD] && run) |=> D_OE_N == OE_ALL_FLOAT)
    else $error("pins driven during host write");
  write_store_a: assert property (mem_we |-> $past(state == ST_HOST) && $past(!filt[SY_WR]))
    else $error("register written outside write strobe");
  read_data_a: assert property ((state == ST_HOST && !filt[SY_RD] && run && $stable(filt[DATA_W-1:NIB_W]) && !mem_we)
    |=> D_OUT[NIB_W-1:0] == $past(rd_nib))
    else $error("read nibble mismatch");
  gate_host_low_a: assert property ((host_act || !run) |=> !TRANSCEIVER_GATE)
    else $error("transceiver gate high during host or load cycle");
  hold_reset_a: assert property (!run |=> state == ST_LOAD && test_cnt == '0 && !DISPLAY_FREEZE_PULSE)
    else $error("state not held while load/reset low");
  config_take_a: assert property (load_rise |=> CONFIG == $past(filt[DATA_W-1:0]) && test_cnt == TEST_SCANS)
    else $error("config or display test not started on load edge");
  test_lamps_a: assert property ((test_cnt != '0 && TRANSCEIVER_GATE) |-> D_OUT[DATA_W-1:PORT_W] == STAT_ALL_ON)
    else $error("display test not showing all lamps");
  freeze_set_a: assert property ((TX_PACKET_END && run) |=> DISPLAY_FREEZE_PULSE)
    else $error("freeze not raised after packet end");
  freeze_clear_a: assert property ((DISPLAY_FREEZE_PULSE && RX_PACKET_START && !TX_PACKET_END) |=> !DISPLAY_FREEZE_PULSE)
    else $error("freeze not dropped on packet start");
  tick_rate_a: assert property (tick |=> !tick [*4] ##1 tick)
    else $error("state rate enable not every five cycles");

  // display side, load state and configuration
  gate_display_a: assert property ((disp_now && !host_act && run) |=> TRANSCEIVER_GATE)
    else $error("transceiver gate low during display cycle");
  port_range_a: assert property (D_OE_N == OE_ALL_DRIVE |-> D_OUT[PORT_W-1:0] <= PORT_LAST)
    else $error("display port number out of range");
  phase_tick_a: assert property ((disp_now && !tick && !host_act && run) |=> state == $past(state))
    else $error("display phase changed between rate enables");
  load_float_a: assert property (state == ST_LOAD |-> D_OE_N == OE_ALL_FLOAT && !TRANSCEIVER_GATE)
    else $error("pins or gate active in load state");
  config_hold_a: assert property (!load_rise |=> $stable(CONFIG))
    else $error("configuration changed without load edge");

  // host side
  latch_release_a: assert property (state == ST_RELEASE |-> DISPLAY_LATCH_PULSE_N && !TRANSCEIVER_GATE)
    else $error("latch or gate active while releasing pins");
  host_hold_a: assert property ((state == ST_HOST && host_act && run) |=> state == ST_HOST)
    else $error("host access left while strobe asserted");
  one_write_a: assert property (mem_we |=> !mem_we)
    else $error("one write strobe stored twice");

  // freeze
  freeze_drop_a: assert property ((freeze_cnt == '0 && !TX_PACKET_END) |=> !DISPLAY_FREEZE_PULSE)
    else $error("freeze held after its count ran out");
  freeze_max_a: assert property (DISPLAY_FREEZE_PULSE |-> frozen_for < FREEZE_W'(FREEZE_CYCLES))
    else $error("freeze stood longer than its limit");
  snap_take_a: assert property (TX_PACKET_END |=> snap == $past(PORT_STATUS))
    else $error("status snapshot not taken at packet end");

  host_write_c: cover property (mem_we);
  host_read_c: cover property (state == ST_HOST && D_OE_N == OE_LOW_NIB);
  freeze_end_c: cover property (DISPLAY_FREEZE_PULSE && freeze_cnt == '0 ##1 !DISPLAY_FREEZE_PULSE);
  test_done_c: cover property ($fell(test_cnt != '0));
  host_abandon_c: cover property (state == ST_LATCH && host_act);
endmodule : repeater_host_display_port

// >>> sim/rhdp_host_model.sv
// far side model: host drive onto the shared pins and the off-chip display latches
`timescale 1ns/10ps
module rhdp_host_model import rhdp_pkg::*; (
  input wire logic clk,
  input wire logic [DATA_W-1:0] d_out,
  input wire logic [DATA_W-1:0] d_oe_n,
  input wire logic [DATA_W-1:0] host_v,
  input wire logic [DATA_W-1:0] host_en,
  input wire logic latch_n,
  output logic [DATA_W-1:0] d_in,
  output logic [DATA_W-1:0] lat [0:7]
);
  logic [DATA_W-1:0] last = 8'h00;
  logic prev_n = 1'b1;
  // pin resolution; undriven bits toggle so a stale level cannot pass
  always_comb begin
    for (int i = 0; i < DATA_W; i++) begin
      d_in[i] = !d_oe_n[i] ? d_out[i] : (host_en[i] ? host_v[i] : ~last[i]);
    end
  end
  // latch word on strobe rise, only while the device drives the pins
  // plain always: the start values above keep floating bits defined from time zero
  always @(posedge clk) begin
    last <= d_in;
    prev_n <= latch_n;
    if (latch_n && !prev_n && d_oe_n == OE_ALL_DRIVE) begin
      lat[d_in[2:0]] <= d_in;
    end
  end
endmodule : rhdp_host_model

// >>> sim/tb.sv
// self-checking bench for the repeater host/display pin port
`timescale 1ns/10ps
module tb import rhdp_pkg::*;;
  logic clk_sys, rst, wr_n, rd_n, load_n, tx_end, rx_start, latch_n, freeze, gate;
  logic [PORT_CNT*STAT_W-1:0] port_status;
  logic [DATA_W-1:0] host_v, host_en, d_in, d_out, d_oe_n, config_q;
  logic [DATA_W-1:0] lat [0:7];
  int miscompares, total_checks;
  // short freeze count keeps the timeout case within the run
  repeater_host_display_port #(.FREEZE_CYCLES(200)) dut_u (.CLK_SYS(clk_sys), .RST(rst), .D_IN(d_in),
    .D_OUT(d_out), .D_OE_N(d_oe_n), .WR_N(wr_n), .RD_N(rd_n), .CONFIG_CAPTURE_RESET_N(load_n),
    .PORT_STATUS(port_status), .TX_PACKET_END(tx_end), .RX_PACKET_START(rx_start),
    .DISPLAY_LATCH_PULSE_N(latch_n), .DISPLAY_FREEZE_PULSE(freeze), .TRANSCEIVER_GATE(gate), .CONFIG(config_q));
  rhdp_host_model host_u (.clk(clk_sys), .d_out(d_out), .d_oe_n(d_oe_n), .host_v(host_v), .host_en(host_en),
    .latch_n(latch_n), .d_in(d_in), .lat(lat));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask : chk
  task automatic wait_gate();
    int n;
    n = 0;
    while (gate !== 1'b1 && n < 60) begin
      cyc(1);
      n++;
    end
    chk({7'h0, gate}, 8'h01);
  endtask : wait_gate
  task automatic chk_lat(input logic [4:0] st, input bit live);
    for (int p = 0; p < PORT_CNT; p++) begin
      chk(lat[p], {live ? 5'(p + 3) : st, 3'(p)});
    end
  endtask : chk_lat
  task automatic t_load(input logic [7:0] cfg);
    host_v = cfg;
    host_en = 8'hff;
    load_n = 1'b0;
    cyc(10);
    chk(d_oe_n, OE_ALL_FLOAT);
    chk({7'h0, gate}, 8'h00);
    load_n = 1'b1;
    cyc(6);
    host_en = 8'h00;
    wait_gate();
    chk(config_q, cfg);
    chk(d_oe_n, OE_ALL_DRIVE);
    chk({3'h0, d_out[7:3]}, 8'h1f);
    cyc(110);
    chk_lat(STAT_ALL_ON, 1'b0);
    $display("load test done");
  endtask : t_load
  task automatic t_write(input logic [3:0] a, input logic [3:0] dt);
    host_v = {a, dt};
    host_en = 8'hff;
    wr_n = 1'b0;
    cyc(6);
    chk(d_oe_n, OE_ALL_FLOAT);
    chk({7'h0, gate}, 8'h00);
    cyc(3);
    wr_n = 1'b1;
    cyc(5);
    host_en = 8'h00;
    wait_gate();
    $display("write test done");
  endtask : t_write
  task automatic t_read(input logic [3:0] a, input logic [3:0] exp);
    host_v = {a, 4'h0};
    host_en = 8'hf0;
    rd_n = 1'b0;
    cyc(12);
    chk(d_oe_n, OE_LOW_NIB);
    chk({7'h0, latch_n}, 8'h01);
    chk({4'h0, d_in[3:0]}, {4'h0, exp});
    rd_n = 1'b1;
    cyc(5);
    host_en = 8'h00;
    wait_gate();
    $display("read test done");
  endtask : t_read
  task automatic t_freeze();
    tx_end = 1'b1;
    cyc(1);
    tx_end = 1'b0;
    cyc(1);
    chk({7'h0, freeze}, 8'h01);
    port_status = '0;
    cyc(110);
    chk_lat(5'h00, 1'b1);
    rx_start = 1'b1;
    cyc(1);
    rx_start = 1'b0;
    cyc(1);
    chk({7'h0, freeze}, 8'h00);
    tx_end = 1'b1;
    cyc(1);
    tx_end = 1'b0;
    cyc(10);
    chk({7'h0, freeze}, 8'h01);
    cyc(189);
    chk({7'h0, freeze}, 8'h01);
    cyc(1);
    chk({7'h0, freeze}, 8'h00);
    cyc(110);
    chk_lat(5'h00, 1'b0);
    $display("freeze test done");
  endtask : t_freeze
  task automatic tally_and_finish();
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #100us;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    {wr_n, rd_n, rst} = 3'b111;
    {load_n, tx_end, rx_start} = 3'b000;
    {host_v, host_en} = 16'h0000;
    for (int p = 0; p < PORT_CNT; p++) begin
      port_status[p*5 +: 5] = 5'(p + 3);
    end
    cyc(4);
    rst = 1'b0;
    t_load(8'ha5);
    // test scans end, then live status must reach the latches
    cyc(560);
    chk_lat(5'h00, 1'b1);
    t_write(4'h3, 4'h9);
    t_write(4'hc, 4'h6);
    t_write(4'h0, 4'ha);
    t_write(4'hf, 4'h5);
    t_read(4'h0, 4'ha);
    t_read(4'hf, 4'h5);
    t_read(4'hc, 4'h6);
    t_freeze();
    t_load(8'h3c);
    t_read(4'h3, 4'h9);
    tally_and_finish();
  end
endmodule : tb
